/* File: shared/pss_params.svh */
// Purpose: constants for the phy status summary upper half
// Assumes: 5-bit management register addresses, 16-bit data
// Notes: definitions only
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ----------------------------------------------------------------------
// management register addresses
// ----------------------------------------------------------------------
`define PSS_ADDR_SUMMARY 5'h10
`define PSS_ADDR_BASIC_STATUS 5'h01
`define PSS_ADDR_NEG_EXPANSION 5'h06
`define PSS_ADDR_INT_STATUS 5'h12
`define PSS_ADDR_FALSE_CARRIER_CNT 5'h14
`define PSS_ADDR_RX_ERROR_CNT 5'h15

// ----------------------------------------------------------------------
// summary register field positions
// ----------------------------------------------------------------------
`define PSS_BIT_RESERVED 15
`define PSS_BIT_CROSSOVER 14
`define PSS_BIT_RX_ERROR 13
`define PSS_BIT_POLARITY 12
`define PSS_BIT_FALSE_CARRIER 11
`define PSS_BIT_SIGNAL_DETECT 10
`define PSS_BIT_DESCRAMBLER_LOCK 9
`define PSS_BIT_PAGE_RECEIVED 8
`define PSS_BIT_INT_PENDING 7
`define PSS_BIT_REMOTE_FAULT 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PSS_RESET_FLAG 1'h0
`define PSS_RESET_DATA 16'h0000

`endif

/* File: shared/pss_pkg.sv */
// Purpose: types for the phy status summary upper half
// Assumes: constants live in pss_params.svh
// Notes: the state struct holds every flop of the block except summary_out
package pss_pkg;

   // ----------------------------------------------------------------------
   // live inputs from the port's status sources
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic auto_crossover_enable;
      logic force_crossover;
      logic crossover_swapped;
      logic rx_error_event;
      logic polarity_inverted;
      logic false_carrier_event;
      logic raw_signal_detect;
      logic descrambler_lock;
      logic signal_detect_qualify;
      logic page_received_event;
      logic interrupt_event;
      logic remote_fault_event;
   } pss_source_type;

   // ----------------------------------------------------------------------
   // block state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic crossover;
      logic rx_error;
      logic polarity;
      logic false_carrier;
      logic signal_detect;
      logic descrambler_lock;
      logic page_received;
      logic int_pending;
      logic remote_fault;
      logic [15:0] rd_data;
   } pss_state_type;

endpackage

/* File: hdl/pss_summary.sv */
// Purpose: upper half (bits 15..6) of the phy status summary register
// Assumes: reads arrive as one-cycle strobes from the management front end
// Notes: bits 5..0 belong elsewhere and read here as zero
//
// Operation
// - bit 15 ignores writes and always reads zero.
// - bit 14 follows crossover enable/force; live when enabled and not forced.
// - bit 14 is one for swapped pairs, zero for normal pairs.
// - bit 13 latches any receive error until receive error counter read.
// - receive error latch clears on counter read, not on summary read.
// - bit 12 copies source polarity bit; cleared only by its own source.
// - bit 11 latches any false carrier until false carrier counter read.
// - false carrier latch clears on reading the false carrier counter.
// - bit 10 latch-low qualified detect: raw detect AND lock when qualify set.
// - with qualify clear, bit 10 follows raw signal detect.
// - bit 9 reports descrambler lock as a latch-low flag.
// - bit 8 mirrors page received; summary read does not clear it.
// - page received mirror clears on negotiation expansion register read.
// - bit 7 shows a pending interrupt, source in interrupt status register.
// - reading interrupt status register clears the pending interrupt.
// - bit 6 sets when partner signals remote fault via negotiation.
// - remote fault clears only on basic status read or reset.

`include "pss_params.svh"

module pss_summary (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic rd_strobe_in,
   input wire logic [4:0] rd_addr_in,
   input wire logic wr_strobe_in,
   input wire logic [15:0] wr_data_in,
   input wire pss_pkg::pss_source_type source_in,
   output logic [15:0] rd_data_out,
   output logic [15:0] summary_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   pss_pkg::pss_state_type state;
   pss_pkg::pss_state_type next_state;
   logic [15:0] summary_word;
   logic [15:0] next_summary;
   logic qualified_detect;
   logic read_summary;
   logic read_rx_count;
   logic read_fc_count;
   logic read_expansion;
   logic read_int_status;
   logic read_basic;
   logic write_unused;

   // ----------------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------------
   // a read of another register reaches here as a clear side effect and loads zero read data
   assign read_summary = rd_strobe_in && (rd_addr_in == `PSS_ADDR_SUMMARY);
   assign read_rx_count = rd_strobe_in && (rd_addr_in == `PSS_ADDR_RX_ERROR_CNT);
   assign read_fc_count = rd_strobe_in && (rd_addr_in == `PSS_ADDR_FALSE_CARRIER_CNT);
   assign read_expansion = rd_strobe_in && (rd_addr_in == `PSS_ADDR_NEG_EXPANSION);
   assign read_int_status = rd_strobe_in && (rd_addr_in == `PSS_ADDR_INT_STATUS);
   assign read_basic = rd_strobe_in && (rd_addr_in == `PSS_ADDR_BASIC_STATUS);
   // the whole register is read only, so writes change nothing
   assign write_unused = wr_strobe_in && (|wr_data_in);

   // qualification switch sits in front of the latch-low flag
   assign qualified_detect = source_in.signal_detect_qualify ?
      (source_in.raw_signal_detect && source_in.descrambler_lock) :
      source_in.raw_signal_detect;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      // force wins over the algorithm; disabled means normal pairs
      if (source_in.force_crossover) begin
         next_state.crossover = 1'h1;
      end else if (source_in.auto_crossover_enable) begin
         next_state.crossover = source_in.crossover_swapped;
      end else begin
         next_state.crossover = 1'h0;
      end
      // latch-high events: a set in the clearing cycle survives
      if (read_rx_count) begin
         next_state.rx_error = 1'h0;
      end
      if (source_in.rx_error_event) begin
         next_state.rx_error = 1'h1;
      end
      if (read_fc_count) begin
         next_state.false_carrier = 1'h0;
      end
      if (source_in.false_carrier_event) begin
         next_state.false_carrier = 1'h1;
      end
      // the polarity source does its own clearing on its own read
      next_state.polarity = source_in.polarity_inverted;
      // latch-low: a summary read reloads the live level, otherwise a drop sticks
      if (read_summary) begin
         next_state.signal_detect = qualified_detect;
         next_state.descrambler_lock = source_in.descrambler_lock;
      end else begin
         next_state.signal_detect = state.signal_detect && qualified_detect;
         next_state.descrambler_lock = state.descrambler_lock &&
            source_in.descrambler_lock;
      end
      // a drop in the very read cycle still reads low next time
      if (read_summary && !qualified_detect) begin
         next_state.signal_detect = 1'h0;
      end
      if (read_expansion) begin
         next_state.page_received = 1'h0;
      end
      if (source_in.page_received_event) begin
         next_state.page_received = 1'h1;
      end
      if (read_int_status) begin
         next_state.int_pending = 1'h0;
      end
      if (source_in.interrupt_event) begin
         next_state.int_pending = 1'h1;
      end
      if (read_basic) begin
         next_state.remote_fault = 1'h0;
      end
      if (source_in.remote_fault_event) begin
         next_state.remote_fault = 1'h1;
      end
      // read data is the value before this read's side effects
      if (rd_strobe_in) begin
         next_state.rd_data = read_summary ? summary_word : `PSS_RESET_DATA;
      end
   end

   // ----------------------------------------------------------------------
   // register image
   // ----------------------------------------------------------------------
   always_comb begin
      summary_word = `PSS_RESET_DATA;
      summary_word[`PSS_BIT_RESERVED] = 1'h0;
      summary_word[`PSS_BIT_CROSSOVER] = state.crossover;
      summary_word[`PSS_BIT_RX_ERROR] = state.rx_error;
      summary_word[`PSS_BIT_POLARITY] = state.polarity;
      summary_word[`PSS_BIT_FALSE_CARRIER] = state.false_carrier;
      summary_word[`PSS_BIT_SIGNAL_DETECT] = state.signal_detect;
      summary_word[`PSS_BIT_DESCRAMBLER_LOCK] = state.descrambler_lock;
      summary_word[`PSS_BIT_PAGE_RECEIVED] = state.page_received;
      summary_word[`PSS_BIT_INT_PENDING] = state.int_pending;
      summary_word[`PSS_BIT_REMOTE_FAULT] = state.remote_fault;
   end

   always_comb begin
      next_summary = `PSS_RESET_DATA;
      next_summary[`PSS_BIT_CROSSOVER] = next_state.crossover;
      next_summary[`PSS_BIT_RX_ERROR] = next_state.rx_error;
      next_summary[`PSS_BIT_POLARITY] = next_state.polarity;
      next_summary[`PSS_BIT_FALSE_CARRIER] = next_state.false_carrier;
      next_summary[`PSS_BIT_SIGNAL_DETECT] = next_state.signal_detect;
      next_summary[`PSS_BIT_DESCRAMBLER_LOCK] = next_state.descrambler_lock;
      next_summary[`PSS_BIT_PAGE_RECEIVED] = next_state.page_received;
      next_summary[`PSS_BIT_INT_PENDING] = next_state.int_pending;
      next_summary[`PSS_BIT_REMOTE_FAULT] = next_state.remote_fault;
   end

   // ----------------------------------------------------------------------
   // flops
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= '0;
         summary_out <= `PSS_RESET_DATA;
      end else begin
         state <= next_state;
         summary_out <= next_summary;
      end
   end

   assign rd_data_out = state.rd_data;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence rx_err_seen;
      source_in.rx_error_event;
   endsequence

   sequence rx_clear_absent;
      !read_rx_count;
   endsequence

   sequence fc_seen;
      source_in.false_carrier_event;
   endsequence

   sequence fc_clear_absent;
      !read_fc_count;
   endsequence

   sequence sd_dropped;
      !qualified_detect;
   endsequence

   sequence summary_unread;
      !read_summary;
   endsequence

   // ----------------------------------------------------------------------
   // checks: image, crossover and flag basics
   // ----------------------------------------------------------------------

   reserved_zero_a: assert property (!summary_out[`PSS_BIT_RESERVED] && !rd_data_out[15])
      else $error("reserved bit reads one");

   crossover_force_a: assert property (source_in.force_crossover |=> summary_out[14])
      else $error("forced crossover not shown");

   crossover_live_a: assert property (
      (source_in.auto_crossover_enable && !source_in.force_crossover)
      |=> summary_out[14] == $past(source_in.crossover_swapped))
      else $error("crossover does not follow swap state");

   rx_error_hold_a: assert property (
      rx_err_seen ##1 rx_clear_absent [*3] |=> summary_out[13])
      else $error("receive error latch lost");

   rx_error_clear_a: assert property (
      read_rx_count && !source_in.rx_error_event |=> !summary_out[13])
      else $error("receive error latch not cleared by counter read");

   polarity_copy_a: assert property (summary_out[12] == $past(source_in.polarity_inverted))
      else $error("polarity mirror wrong");

   false_carrier_a: assert property (fc_seen |=> summary_out[11])
      else $error("false carrier latch not set");

   fc_hold_a: assert property (
      fc_seen ##1 fc_clear_absent [*3] |=> summary_out[11])
      else $error("false carrier latch lost");

   fc_clear_a: assert property (
      read_fc_count && !source_in.false_carrier_event |=> !summary_out[11])
      else $error("false carrier latch not cleared by counter read");

   qualify_detect_a: assert property (
      read_summary |=> summary_out[10] == $past(qualified_detect))
      else $error("signal detect reload wrong");

   lock_low_a: assert property (
      !source_in.descrambler_lock ##1 !read_summary |=> !summary_out[9])
      else $error("descrambler lock drop not held");

   page_clear_a: assert property (
      state.page_received && read_summary && !read_expansion |=> summary_out[8])
      else $error("page received cleared by summary read");

   int_clear_a: assert property (
      read_int_status && !source_in.interrupt_event |=> !summary_out[7])
      else $error("pending interrupt not cleared");

   fault_hold_a: assert property (
      source_in.remote_fault_event ##1 (!read_basic) [*2] |=> summary_out[6])
      else $error("remote fault lost without basic status read");

   // ----------------------------------------------------------------------
   // checks: latch-high set, hold and clear
   // ----------------------------------------------------------------------
   // each flag gets its own set and clear check so a swapped clear address shows
   rx_error_set_a: assert property (rx_err_seen |=> summary_out[13])
      else $error("receive error latch not set");

   rx_keep_a: assert property (
      summary_out[13] && !read_rx_count |=> summary_out[13])
      else $error("receive error latch lost without counter read");

   page_set_a: assert property (source_in.page_received_event |=> summary_out[8])
      else $error("page received mirror not set");

   page_keep_a: assert property (
      summary_out[8] && !read_expansion |=> summary_out[8])
      else $error("page received mirror lost without expansion read");

   page_drop_a: assert property (
      read_expansion && !source_in.page_received_event |=> !summary_out[8])
      else $error("page received mirror not cleared");

   int_set_a: assert property (source_in.interrupt_event |=> summary_out[7])
      else $error("pending interrupt not shown");

   int_hold_a: assert property (
      summary_out[7] && !read_int_status |=> summary_out[7])
      else $error("pending interrupt lost without status read");

   fault_set_a: assert property (source_in.remote_fault_event |=> summary_out[6])
      else $error("remote fault not shown");

   fault_keep_a: assert property (
      summary_out[6] && !read_basic |=> summary_out[6])
      else $error("remote fault lost without basic status read");

   fault_clear_a: assert property (
      read_basic && !source_in.remote_fault_event |=> !summary_out[6])
      else $error("remote fault not cleared by basic status read");

   // ----------------------------------------------------------------------
   // checks: crossover and latch-low flags
   // ----------------------------------------------------------------------
   crossover_off_a: assert property (
      !source_in.auto_crossover_enable && !source_in.force_crossover |=> !summary_out[14])
      else $error("crossover shown while disabled");

   detect_hold_a: assert property (
      sd_dropped ##1 summary_unread |=> !summary_out[10])
      else $error("signal detect drop not held");

   qualify_on_a: assert property (
      source_in.signal_detect_qualify && read_summary
      |=> summary_out[10] == $past(source_in.raw_signal_detect && source_in.descrambler_lock))
      else $error("qualified detect not raw detect and lock");

   qualify_off_a: assert property (
      !source_in.signal_detect_qualify && read_summary
      |=> summary_out[10] == $past(source_in.raw_signal_detect))
      else $error("unqualified detect not raw detect");

   lock_reload_a: assert property (
      read_summary |=> summary_out[9] == $past(source_in.descrambler_lock))
      else $error("descrambler lock reload wrong");

   // ----------------------------------------------------------------------
   // checks: read port
   // ----------------------------------------------------------------------
   // read data is compared with the live image so the side-effect ordering is pinned
   read_data_a: assert property (
      read_summary |=> rd_data_out == $past(summary_out))
      else $error("summary read data wrong");

   other_read_a: assert property (
      rd_strobe_in && !read_summary |=> rd_data_out == `PSS_RESET_DATA)
      else $error("other register read returned data");

   read_hold_a: assert property (!rd_strobe_in |=> $stable(rd_data_out))
      else $error("read data changed without a read");

   // writes are decoded only to prove they land nowhere
   write_ignored_a: assert property (
      write_unused && !rd_strobe_in |=> $stable(rd_data_out) && !summary_out[15])
      else $error("write disturbed the register");

endmodule

/* File: testbench/pss_mgmt_host.sv */
// Purpose: station management controller model issuing register accesses
// Assumes: one-cycle read strobe, answer registered one edge later
// Notes: address drives the inverse of the last value when idle
module pss_mgmt_host (
   input wire logic clk_in,
   input wire logic [15:0] rd_data_in,
   output logic rd_strobe_out,
   output logic [4:0] rd_addr_out,
   output logic wr_strobe_out,
   output logic [15:0] wr_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // idle state
   // ----------------------------------------------------------------------
   initial begin
      rd_strobe_out = 1'b0;
      rd_addr_out = 5'h1f;
      wr_strobe_out = 1'b0;
      wr_data_out = 16'h0000;
   end

   // ----------------------------------------------------------------------
   // accesses
   // ----------------------------------------------------------------------
   // idle address is scrambled so a design that ignores the strobe is caught
   task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
      @(posedge clk_in);
      rd_strobe_out <= 1'b1;
      rd_addr_out <= addr;
      @(posedge clk_in);
      rd_strobe_out <= 1'b0;
      rd_addr_out <= ~addr;
      #1;
      data = rd_data_in;
   endtask

   task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
      @(posedge clk_in);
      wr_strobe_out <= 1'b1;
      rd_addr_out <= addr;
      wr_data_out <= data;
      @(posedge clk_in);
      wr_strobe_out <= 1'b0;
      rd_addr_out <= ~addr;
      wr_data_out <= ~data;
   endtask
endmodule

/* File: testbench/pss_summary_tb_top.sv */
// Purpose: self-checking bench for the phy status summary upper half
// Assumes: sources driven directly, management reads through the host model
// Notes: expectations come from the field positions and addresses only
`include "pss_params.svh"

module pss_summary_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_in;
   logic reset_in;
   logic rd_strobe;
   logic wr_strobe;
   logic [4:0] rd_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [15:0] summary;
   logic [15:0] seen;
   pss_pkg::pss_source_type src;
   int bad_count;
   int comparisons;
   int cycles;
   // event position in the source struct, summary bit, clearing address
   int ev[5] = '{8, 6, 2, 1, 0};
   int pos[5] = '{13, 11, 8, 7, 6};
   logic [4:0] clr[5] = '{5'h15, 5'h14, 5'h06, 5'h12, 5'h01};
   // enable, force, swapped, expected crossover bit
   logic [3:0] xo[4] = '{4'b1011, 4'b1000, 4'b1101, 4'b0010};

   pss_summary uut (
      .clk_in(clk_in), .reset_in(reset_in), .rd_strobe_in(rd_strobe),
      .rd_addr_in(rd_addr), .wr_strobe_in(wr_strobe), .wr_data_in(wr_data),
      .source_in(src), .rd_data_out(rd_data), .summary_out(summary)
   );

   pss_mgmt_host host (
      .clk_in(clk_in), .rd_data_in(rd_data), .rd_strobe_out(rd_strobe),
      .rd_addr_out(rd_addr), .wr_strobe_out(wr_strobe), .wr_data_out(wr_data)
   );

   // ----------------------------------------------------------------------
   // clock, timeout and reporting
   // ----------------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // the whole run needs about a hundred cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial begin
      reset_in = 1'b1;
      src = '0;
      repeat (2) @(posedge clk_in);
      check("summary in reset", summary, 16'h0000);
      check("read data in reset", rd_data, 16'h0000);
      reset_in <= 1'b0;
      host.write_reg(`PSS_ADDR_SUMMARY, 16'hffff);
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      check("summary after write", seen, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         src.auto_crossover_enable <= xo[i][3];
         src.force_crossover <= xo[i][2];
         src.crossover_swapped <= xo[i][1];
         settle(2);
         check("crossover", {15'h0000, summary[14]}, {15'h0000, xo[i][0]});
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in);
         src[ev[i]] <= 1'b1;
         @(posedge clk_in);
         src[ev[i]] <= 1'b0;
         settle(1);
         check("flag set", {15'h0000, summary[pos[i]]}, 16'h0001);
         host.read_reg(`PSS_ADDR_SUMMARY, seen);
         check("flag read", {15'h0000, seen[pos[i]]}, 16'h0001);
         host.read_reg(clr[(i + 1) % 5], seen);
         check("other read data", seen, 16'h0000);
         settle(1);
         check("flag kept", {15'h0000, summary[pos[i]]}, 16'h0001);
         host.read_reg(clr[i], seen);
         settle(1);
         check("flag cleared", {15'h0000, summary[pos[i]]}, 16'h0000);
      end
      @(posedge clk_in);
      src.polarity_inverted <= 1'b1;
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      settle(1);
      check("polarity kept", {15'h0000, summary[12]}, 16'h0001);
      @(posedge clk_in);
      src.polarity_inverted <= 1'b0;
      settle(2);
      check("polarity follows", {15'h0000, summary[12]}, 16'h0000);
      @(posedge clk_in);
      src.raw_signal_detect <= 1'b1;
      src.descrambler_lock <= 1'b1;
      src.signal_detect_qualify <= 1'b1;
      settle(2);
      check("detect before read", {14'h0000, summary[10:9]}, 16'h0000);
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      settle(1);
      check("detect live", {14'h0000, summary[10:9]}, 16'h0003);
      @(posedge clk_in);
      src.descrambler_lock <= 1'b0;
      @(posedge clk_in);
      src.descrambler_lock <= 1'b1;
      settle(3);
      check("detect held low", {14'h0000, summary[10:9]}, 16'h0000);
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      check("detect read low", {14'h0000, seen[10:9]}, 16'h0000);
      settle(1);
      check("detect reloaded", {14'h0000, summary[10:9]}, 16'h0003);
      @(posedge clk_in);
      src.signal_detect_qualify <= 1'b0;
      src.descrambler_lock <= 1'b0;
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      host.read_reg(`PSS_ADDR_SUMMARY, seen);
      settle(1);
      check("raw detect only", {14'h0000, summary[10:9]}, 16'h0002);
      @(posedge clk_in);
      src.raw_signal_detect <= 1'b0;
      settle(2);
      check("raw detect drop", {14'h0000, summary[10:9]}, 16'h0000);
      wrap_up();
   end
endmodule
